/* File: bench/adc_pin_analog_select_tb_top.sv */
// testbench: apb-driven checks of analog/digital pin steering
`timescale 1ns/1ns
`default_nettype none
module adc_pin_analog_select_tb_top;
  import pin_select_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [8:0]  pad_in = '0, pad_out, pad_oe, converter_in;
  int num_errors = 0, comparisons = 0;
  typedef struct {logic [8:0] cfg, dir, out, pad, lvl, conv;} row_t;
  row_t rows [4] = '{'{9'h000, 9'h1FF, 9'h000, 9'h155, 9'h000, 9'h155},
    '{9'h1FF, 9'h1FF, 9'h000, 9'h0AA, 9'h0AA, 9'h000},
    '{9'h000, 9'h000, 9'h0F0, 9'h000, 9'h000, 9'h0F0},
    '{9'h0F0, 9'h00F, 9'h1C3, 9'h1A5, 9'h0C0, 9'h105}};
  adc_pin_analog_select dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .converter_in(converter_in));
  initial forever #2 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // each call opens one edge after the last so no signal is set twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    t = 0;
    do begin @(posedge clk); t++; end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    check(pad_oe, 32'h0);
    apb(0, addr_pin_config, 0); check(rd, 32'h0);
    apb(0, addr_pin_dir, 0); check(rd, 32'h0000_FFFF);
    apb(0, 12'h020, 0); check(rd, unmapped_read);
    foreach (rows[i]) begin
      apb(1, addr_pin_config, rows[i].cfg);
      apb(1, addr_pin_dir, rows[i].dir);
      apb(1, addr_pin_out, rows[i].out);
      apb(1, addr_input_select, 32'h0F0F * i);
      pad_in <= (rows[i].pad & rows[i].dir) | (rows[i].out & ~rows[i].dir);
      repeat (5) @(posedge clk);
      apb(0, addr_pin_level, 0); check(rd, rows[i].lvl);
      check(converter_in, rows[i].conv);
      apb(0, addr_conv_level, 0); check(rd, rows[i].conv);
      check(pad_oe ^ rows[i].dir, 32'h1FF);
      check(pad_out, rows[i].out);
    end
    // reset again in mid-run: every pin must fall back to analog
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    apb(0, addr_pin_config, 0); check(rd, 32'h0);
    check(pad_oe, 32'h0);
    check(pad_out, 32'h0);
    apb(0, addr_pin_level, 0); check(rd, 32'h0);
    give_verdict;
  end
endmodule : adc_pin_analog_select_tb_top
`default_nettype wire

/* File: bench/pin_select_assertions.sv */
// checker: port-level properties of the pin select block
`timescale 1ns/1ns
`default_nettype none
module pin_select_checker import pin_select_pkg::*; #(parameter int n = 9) (
  input wire logic         clk, nrst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata, prdata,
  input wire logic [n-1:0] pad_out, pad_oe, converter_in
);
  logic [n-1:0] cfg;
  // shadow of the mode bits, updated at the write access edge
  always_ff @(posedge clk) begin
    if (!nrst) cfg <= '0;
    else if (psel && penable && pwrite && pready && paddr == addr_pin_config)
      cfg <= pwdata[n-1:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_setup_answer: assert property (psel && !penable |=> penable && pready)
    else $error("no ready in access cycle");
  a_ready_access: assert property (pready |-> penable && $past(!penable))
    else $error("ready outside access cycle");
  a_no_error: assert property (pslverr == 1'b0) else $error("slave error");
  a_reset_analog: assert property ($rose(nrst) |-> pad_oe == '0)
    else $error("pins not input after reset");
  a_digital_blocked: assert property (
    (cfg & $past(cfg) & converter_in) == '0)
    else $error("digital pin reached converter");
  a_analog_reads_zero: assert property (psel && !penable && !pwrite &&
    paddr == addr_pin_level |=> (prdata[n-1:0] & ~cfg) == '0)
    else $error("analog pin read nonzero");
  a_output_converts: assert property ((~cfg & ~$past(cfg) & pad_oe &
    $past(pad_oe) & ~(pad_out ^ $past(pad_out)) & (converter_in ^ pad_out))
    == '0) else $error("driven level not converted");
  cover property (psel && penable && pwrite && paddr == addr_pin_config);
  cover property (|(pad_oe & ~cfg));
  cover property (|cfg && |converter_in);
  cover property ($rose(nrst) && |cfg);
endmodule : pin_select_checker
bind adc_pin_analog_select pin_select_checker #(.n(n)) chk (.clk(clk),
  .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pad_out(pad_out), .pad_oe(pad_oe),
  .converter_in(converter_in));
`default_nettype wire

/* File: hdl/adc_pin_analog_select.sv */
// module: apb register file and pad steering for converter-capable pins
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - an output pin selected for conversion converts its own driven level
// - conversion ignores primary input select fields; direction bits only pick which level is converted
// - pin level reads return zero for every analog-configured pin
// - a digital-mode pin never passes its level to the converter
module adc_pin_analog_select #(
  parameter int n = pin_select_pkg::num_pins
) (
  input  wire  logic        clk,
  input  wire  logic        nrst,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  input  wire  logic [3:0]  pstrb,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  input  wire  logic [n-1:0] pad_in,
  output var   logic [n-1:0] pad_out,
  output var   logic [n-1:0] pad_oe,
  output var   logic [n-1:0] converter_in
);
  import pin_select_pkg::*;

  // the register map is 16 bits wide, so no more pins can be served
  if (n < 1 || n > 16) begin : g_bad_pin_count
    $error("pin count must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  pin_select_if #(.n(n)) ps ();

  logic [15:0] pin_config;
  logic [15:0] pin_dir;
  logic [15:0] pin_out;
  logic [15:0] input_select;
  logic [n-1:0] pad_meta;
  logic [n-1:0] pad_sync;
  logic         wr_en;
  logic         rd_en;
  logic [31:0]  next_prdata;
  logic         wr_config;
  logic         wr_dir;
  logic         wr_out;
  logic         wr_select;
  logic         setup_phase;
  logic         access_phase;

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : lane_merge

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] target);
    logic hit;
    hit = (a == target);
    return hit;
  endfunction : addr_hit

  function automatic logic [31:0] pad16(input logic [15:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[15:0] = v;
    return r;
  endfunction : pad16

  function automatic logic [31:0] widen(input logic [n-1:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[n-1:0] = v;
    return r;
  endfunction : widen

  ////////////////////////////////////////////////////////////////////////////
  // pads come from outside the clock domain
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_meta <= '0;
    end else begin
      pad_meta <= pad_in;
    end
  end

  // only this second stage may read the first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_sync <= '0;
    end else begin
      pad_sync <= pad_meta;
    end
  end

  assign ps.digital_mode = pin_config[n-1:0];
  assign ps.dir_input    = pin_dir[n-1:0];
  assign ps.out_level    = pin_out[n-1:0];
  assign ps.pad_level    = pad_sync;

  pin_pad_mux #(.n(n)) u_mux (.ps(ps.pads));

  ////////////////////////////////////////////////////////////////////////////
  // zero wait states: access phase completes in its first cycle
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_en        = access_phase && pwrite;
  assign rd_en        = setup_phase && !pwrite;

  // one strobe per writable register; unmapped writes hit nothing
  assign wr_config = wr_en && addr_hit(paddr, addr_pin_config);
  assign wr_dir    = wr_en && addr_hit(paddr, addr_pin_dir);
  assign wr_out    = wr_en && addr_hit(paddr, addr_pin_out);
  assign wr_select = wr_en && addr_hit(paddr, addr_input_select);

  ////////////////////////////////////////////////////////////////////////////
  // mode bits: clear is analog, set is digital; reset leaves all analog
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_config <= pin_config_reset;
    end else if (wr_config) begin
      pin_config <= lane_merge(pin_config, pwdata, pstrb);
    end
  end

  // direction resets to input so no pad is driven out of reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_dir <= pin_dir_reset;
    end else if (wr_dir) begin
      pin_dir <= lane_merge(pin_dir, pwdata, pstrb);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_out <= pin_out_reset;
    end else if (wr_out) begin
      pin_out <= lane_merge(pin_out, pwdata, pstrb);
    end
  end

  // stored for software only; nothing downstream reads it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      input_select <= 16'h0000;
    end else if (wr_select) begin
      input_select <= lane_merge(input_select, pwdata, pstrb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_prdata = unmapped_read;
    case (paddr)
      addr_pin_config:   next_prdata = pad16(pin_config);
      addr_pin_dir:      next_prdata = pad16(pin_dir);
      addr_pin_out:      next_prdata = pad16(pin_out);
      addr_pin_level:    next_prdata = widen(ps.port_read);
      addr_input_select: next_prdata = pad16(input_select);
      addr_conv_level:   next_prdata = widen(ps.conv_path);
      default:           next_prdata = unmapped_read;
    endcase
  end

  // read data latched in setup so the access phase answers from a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

  // ready follows every setup cycle, so there are never wait states
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // no access is refused; unmapped reads just return zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter sees the pin path alone; select fields and direction do not
  // gate it, a software fault of direction only changes what is converted
  always_ff @(posedge clk) begin
    if (!nrst) begin
      converter_in <= '0;
    end else begin
      converter_in <= ps.conv_path;
    end
  end

  // pad driver only enabled on output pins; software owns this for analog use
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_out <= '0;
    end else begin
      pad_out <= pin_out[n-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_oe <= '0;
    end else begin
      pad_oe <= ~pin_dir[n-1:0];
    end
  end
endmodule : adc_pin_analog_select
`default_nettype wire

/* File: hdl/pin_pad_mux.sv */
// module: combinational per-pin analog/digital steering
`timescale 1ns/1ns
`default_nettype none
module pin_pad_mux #(
  parameter int n = 9
) (
  pin_select_if.pads ps
);
  always_comb begin
    for (int i = 0; i < n; i++) begin
      // an output pin presents its driven level, so that level gets converted
      ps.pad_drive[i] = ps.dir_input[i] ? ps.pad_level[i]
                                        : ps.out_level[i];
      // digital mode cuts the converter path off
      ps.conv_path[i] = ps.digital_mode[i] ? 1'b0
                                           : ps.pad_drive[i];
      // analog pins read back as cleared whatever level sits on them
      ps.port_read[i] = ps.digital_mode[i] ? ps.pad_drive[i] : 1'b0;
    end
  end
endmodule : pin_pad_mux
`default_nettype wire

/* File: hdl/pin_select_if.sv */
// interface: per-pin configuration carried from the register file to the pads
`timescale 1ns/1ns
`default_nettype none
interface pin_select_if #(parameter int n = 9);
  logic [n-1:0] digital_mode;
  logic [n-1:0] dir_input;
  logic [n-1:0] out_level;
  logic [n-1:0] pad_level;
  logic [n-1:0] port_read;
  logic [n-1:0] conv_path;
  logic [n-1:0] pad_drive;
  modport regs (output digital_mode, output dir_input, output out_level,
                input port_read, input conv_path, input pad_drive);
  modport pads (input digital_mode, input dir_input, input out_level,
                input pad_level, output port_read, output conv_path,
                output pad_drive);
endinterface : pin_select_if
`default_nettype wire

/* File: hdl/pin_select_pkg.sv */
// package: register map, field layout and reset values for analog pin select
package pin_select_pkg;
  localparam int          num_pins          = 9;
  localparam int          sel_width         = 4;
  localparam logic [11:0] addr_pin_config   = 12'h000;
  localparam logic [11:0] addr_pin_dir      = 12'h004;
  localparam logic [11:0] addr_pin_out      = 12'h008;
  localparam logic [11:0] addr_pin_level    = 12'h00C;
  localparam logic [11:0] addr_input_select = 12'h010;
  localparam logic [11:0] addr_conv_level   = 12'h014;
  localparam logic [15:0] pin_config_reset  = 16'h0000;
  localparam logic [15:0] pin_dir_reset     = 16'hFFFF;
  localparam logic [15:0] pin_out_reset     = 16'h0000;
  localparam int          sel_a_pos         = 0;
  localparam int          sel_b_pos         = 8;
  localparam logic [31:0] unmapped_read     = 32'h0000_0000;
endpackage : pin_select_pkg
